// file: logic/prio_regs_pkg.sv
// package: map, field layout, reset values and carriers of the priority bank
package prio_regs_pkg;
  // ****************
  // sizes
  // ****************
  localparam int N_SRC   = 19;
  localparam int N_REG   = 6;
  localparam int ADDR_W  = 8;
  localparam int FIELD_W = 3;
  localparam int HALF_W  = 16;

  // ****************
  // register byte offsets
  // ****************
  localparam logic [ADDR_W-1:0] REG_OFS [N_REG] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};

  // ****************
  // field values and bus answers
  // ****************
  localparam logic [FIELD_W-1:0] FIELD_RESET = 3'h4;
  localparam logic [FIELD_W-1:0] LEVEL_OFF   = 3'h0;
  localparam logic [FIELD_W-1:0] LEVEL_LOW   = 3'h1;
  localparam logic [FIELD_W-1:0] LEVEL_TOP   = 3'h7;
  localparam logic [1:0]         RESP_OKAY   = 2'h0;
  localparam logic [1:0]         RESP_SLVERR = 2'h2;
  localparam logic [15:0]        HI_ZERO     = 16'h0000;

  // ****************
  // source placement: register index and field lsb per source
  // ****************
  localparam int SRC_CAN_EVENT = 8;
  localparam int SRC_CAN_RX    = 9;
  localparam logic [2:0] SRC_REG [N_SRC] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h1, 3'h1, 3'h1, 3'h2, 3'h2,
                                             3'h2, 3'h2, 3'h3, 3'h3, 3'h3, 3'h4, 3'h4, 3'h5, 3'h5};
  localparam int SRC_LSB [N_SRC] = '{12, 8, 4, 0, 12, 8, 4, 0, 12, 8, 4, 0, 8, 4, 0, 8, 4, 8, 4};

  // ****************
  // carriers
  // ****************
  typedef struct packed {
    logic              en;
    logic [2:0]        idx;
    logic [HALF_W-1:0] data;
    logic [1:0]        strb;
  } reg_wr_t;

  typedef struct packed {
    logic       hit;
    logic [2:0] idx;
  } reg_sel_t;

  // word address to register index, miss on anything else
  function automatic reg_sel_t decode_addr(input logic [ADDR_W-1:0] addr);
    reg_sel_t sel;
    sel = '0;
    for (int i = 0; i < N_REG; i++) begin
      if (addr == REG_OFS[i]) begin
        sel.hit = 1'b1;
        sel.idx = 3'(i);
      end
    end
    return sel;
  endfunction : decode_addr

  // field code to level: linear, code zero disables, absent source disabled
  function automatic logic [FIELD_W-1:0] prio_level(input logic [FIELD_W-1:0] code, input logic present);
    return present ? code : LEVEL_OFF;
  endfunction : prio_level
endpackage : prio_regs_pkg

// file: logic/axil_reg_port.sv
// module: axi4-lite slave port that turns bus cycles into register strobes
`timescale 1ns/1ns
module axil_reg_port (
  // clock and reset
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  // write channels
  input  wire logic [prio_regs_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  // read channels
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  // register side
  input  wire prio_regs_pkg::reg_sel_t       rd_sel,
  input  wire logic [15:0]                   rd_word,
  output prio_regs_pkg::reg_wr_t             wr
);
  typedef struct packed {
    logic                          awready;
    logic                          wready;
    logic                          aw_held;
    logic [prio_regs_pkg::ADDR_W-1:0] aw_addr;
    logic                          w_held;
    logic [15:0]                   w_data;
    logic [1:0]                    w_strb;
    logic                          bvalid;
    logic [1:0]                    bresp;
    logic                          arready;
    logic                          rvalid;
    logic [31:0]                   rdata;
    logic [1:0]                    rresp;
  } port_state_t;

  port_state_t s_ff, nxt_s;
  prio_regs_pkg::reg_sel_t wsel;

  // channel handshakes, write commit once both halves are held
  always_comb begin
    nxt_s = s_ff;
    wr    = '0;
    wsel  = prio_regs_pkg::decode_addr(s_ff.aw_addr);
    if (s_axi_awvalid && s_ff.awready) begin
      nxt_s.aw_held = 1'b1;
      nxt_s.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_ff.wready) begin
      nxt_s.w_held = 1'b1;
      nxt_s.w_data = s_axi_wdata[15:0];
      nxt_s.w_strb = s_axi_wstrb[1:0];
    end
    if (s_ff.bvalid && s_axi_bready) nxt_s.bvalid = 1'b0;
    if (s_ff.aw_held && s_ff.w_held && !s_ff.bvalid) begin
      wr.en         = wsel.hit;
      wr.idx        = wsel.idx;
      wr.data       = s_ff.w_data;
      wr.strb       = s_ff.w_strb;
      nxt_s.bvalid  = 1'b1;
      nxt_s.bresp   = wsel.hit ? prio_regs_pkg::RESP_OKAY : prio_regs_pkg::RESP_SLVERR;
      nxt_s.aw_held = 1'b0;
      nxt_s.w_held  = 1'b0;
    end
    nxt_s.awready = !nxt_s.aw_held;
    nxt_s.wready  = !nxt_s.w_held;
    if (s_ff.rvalid && s_axi_rready) begin
      nxt_s.rvalid  = 1'b0;
      nxt_s.arready = 1'b1;
    end
    if (s_axi_arvalid && s_ff.arready) begin
      nxt_s.rvalid  = 1'b1;
      nxt_s.arready = 1'b0;
      nxt_s.rdata   = {prio_regs_pkg::HI_ZERO, rd_sel.hit ? rd_word : prio_regs_pkg::HI_ZERO};
      nxt_s.rresp   = rd_sel.hit ? prio_regs_pkg::RESP_OKAY : prio_regs_pkg::RESP_SLVERR;
    end
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_ff <= '{awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign s_axi_awready = s_ff.awready;
  assign s_axi_wready  = s_ff.wready;
  assign s_axi_bvalid  = s_ff.bvalid;
  assign s_axi_bresp   = s_ff.bresp;
  assign s_axi_arready = s_ff.arready;
  assign s_axi_rvalid  = s_ff.rvalid;
  assign s_axi_rdata   = s_ff.rdata;
  assign s_axi_rresp   = s_ff.rresp;
endmodule : axil_reg_port

// file: logic/prio_regs.sv
// module: bank of six interrupt priority control registers for nineteen sources
`timescale 1ns/1ns

// ****************
// source order on source_flag, source_level and source_req
// ****************
//  0 timer4_priority          1 compare4_priority       2 compare3_priority
//  3 dma_ch2_done_priority    4 uart2_transmit_priority 5 uart2_receive_priority
//  6 ext_irq2_priority        7 timer5_priority         8 can_event_priority
//  9 can_receive_priority    10 spi2_event_priority    11 spi2_error_priority
// 12 capture4_priority       13 capture3_priority      14 dma_ch3_done_priority
// 15 i2c2_master_priority    16 i2c2_slave_priority    17 ext_irq4_priority
// 18 ext_irq3_priority

// Overview of operation
// - field code 111 gives its source level 7, the highest.
// - field code 001 gives its source level 1, the lowest active.
// - field code 000 disables the source; it never requests, whatever its flag.
// - unimplemented bits read zero and ignore writes.
// - reset loads every field with 100, level 4; all fields read and write.
// - register 0: timer4 14-12, compare4 10-8, compare3 6-4, dma ch2 2-0.
// - register 1: uart2 tx 14-12, uart2 rx 10-8, ext irq2 6-4, timer5 2-0.
// - register 2: can event 14-12, can receive 10-8, spi2 event 6-4, spi2 error 2-0.
// - without the can controller both can sources stay disabled.
// - register 3: bits 15-11 empty; capture4 10-8, capture3 6-4, dma ch3 2-0.
// - register 4: i2c2 master 10-8, i2c2 slave 6-4, rest zero.
// - register 5: ext irq4 10-8, ext irq3 6-4, rest zero.
module prio_regs #(
  parameter bit CAN_PRESENT = 1'b1
) (
  // clock and reset
  input  wire logic                                  aclk,
  input  wire logic                                  aresetn,
  // axi4-lite write address and data
  input  wire logic [prio_regs_pkg::ADDR_W-1:0]      s_axi_awaddr,
  input  wire logic [2:0]                            s_axi_awprot,
  input  wire logic                                  s_axi_awvalid,
  output logic                                       s_axi_awready,
  input  wire logic [31:0]                           s_axi_wdata,
  input  wire logic [3:0]                            s_axi_wstrb,
  input  wire logic                                  s_axi_wvalid,
  output logic                                       s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                                 s_axi_bresp,
  output logic                                       s_axi_bvalid,
  input  wire logic                                  s_axi_bready,
  // axi4-lite read
  input  wire logic [prio_regs_pkg::ADDR_W-1:0]      s_axi_araddr,
  input  wire logic [2:0]                            s_axi_arprot,
  input  wire logic                                  s_axi_arvalid,
  output logic                                       s_axi_arready,
  output logic [31:0]                                s_axi_rdata,
  output logic [1:0]                                 s_axi_rresp,
  output logic                                       s_axi_rvalid,
  input  wire logic                                  s_axi_rready,
  // interrupt flags from the peripherals
  input  wire logic [prio_regs_pkg::N_SRC-1:0]       source_flag,
  // to the arbitration logic
  output logic [prio_regs_pkg::N_SRC-1:0][2:0]       source_level,
  output logic [prio_regs_pkg::N_SRC-1:0]            source_req
);
  // ****************
  // state
  // ****************
  typedef struct packed {
    logic [prio_regs_pkg::N_SRC-1:0][2:0] field;
    logic [prio_regs_pkg::N_SRC-1:0][2:0] level;
    logic [prio_regs_pkg::N_SRC-1:0]      req;
  } bank_state_t;

  bank_state_t             s_ff;
  bank_state_t             nxt_s;
  prio_regs_pkg::reg_wr_t  wr;
  prio_regs_pkg::reg_sel_t rd_sel;
  logic [15:0]             rd_word;

  // protection bits carry no meaning here
  logic unused_prot;
  assign unused_prot = ^{s_axi_awprot, s_axi_arprot};

  // a source is present unless it is a can source on a part without can
  function automatic logic src_present(input int i);
    return CAN_PRESENT || (i != prio_regs_pkg::SRC_CAN_EVENT && i != prio_regs_pkg::SRC_CAN_RX);
  endfunction : src_present

  // assemble one register image from the fields; other bits stay zero
  function automatic logic [15:0] reg_image(input logic [2:0] idx,
                                            input logic [prio_regs_pkg::N_SRC-1:0][2:0] f);
    logic [15:0] w;
    w = prio_regs_pkg::HI_ZERO;
    for (int i = 0; i < prio_regs_pkg::N_SRC; i++) begin
      if (prio_regs_pkg::SRC_REG[i] == idx) begin
        w[prio_regs_pkg::SRC_LSB[i] +: 3] = f[i];
      end
    end
    return w;
  endfunction : reg_image

  // ****************
  // bus port
  // ****************
  axil_reg_port u_port (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .rd_sel        (rd_sel),
    .rd_word       (rd_word),
    .wr            (wr)
  );

  // read image for the address on the read channel
  always_comb begin
    rd_sel  = prio_regs_pkg::decode_addr(s_axi_araddr);
    rd_word = reg_image(rd_sel.idx, s_ff.field);
  end

  // ****************
  // fields, levels and requests
  // ****************
  // field update by byte lane, then level and request from the new field
  always_comb begin
    nxt_s = s_ff;
    for (int i = 0; i < prio_regs_pkg::N_SRC; i++) begin
      if (wr.en && wr.idx == prio_regs_pkg::SRC_REG[i] && wr.strb[prio_regs_pkg::SRC_LSB[i] / 8]) begin
        nxt_s.field[i] = wr.data[prio_regs_pkg::SRC_LSB[i] +: 3];
      end
      nxt_s.level[i] = prio_regs_pkg::prio_level(nxt_s.field[i], src_present(i));
      nxt_s.req[i]   = source_flag[i] && (nxt_s.level[i] != prio_regs_pkg::LEVEL_OFF);
    end
  end

  // state register, every field back to code 100, level 4 except absent can sources at level 0
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < prio_regs_pkg::N_SRC; i++) begin
        s_ff.field[i] <= prio_regs_pkg::FIELD_RESET;
        s_ff.level[i] <= src_present(i) ? prio_regs_pkg::FIELD_RESET : prio_regs_pkg::LEVEL_OFF;
      end
      s_ff.req <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign source_level = s_ff.level;
  assign source_req   = s_ff.req;

  // ****************
  // checks
  // ****************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // top code gives top level on a present source
  chk_code_seven_top: assert property (
    s_ff.field[0] == prio_regs_pkg::LEVEL_TOP |-> source_level[0] == 3'h7
  ) else $error("timer4 code 111 not at level 7");

  // code one gives level one and a flag then requests
  chk_code_one_low: assert property (
    (!wr.en && s_ff.field[10] == prio_regs_pkg::LEVEL_LOW) ##0 source_flag[10] |=> source_req[10] && source_level[10] == 3'h1
  ) else $error("spi2 event code 001 not level 1 request");

  // disabled source never requests however long its flag stands
  generate
    for (genvar g = 0; g < prio_regs_pkg::N_SRC; g++) begin : g_off
      chk_off_no_req: assert property (
        source_level[g] == prio_regs_pkg::LEVEL_OFF |-> !source_req[g]
      ) else $error("disabled source requested");
      chk_flag_to_req: assert property (
        source_flag[g] && nxt_s.level[g] != 3'h0 |=> source_req[g]
      ) else $error("enabled flagged source did not request");
    end
  endgenerate

  // middle codes map one to one
  chk_code_linear: assert property (
    s_ff.field[17] inside {[3'h2:3'h6]} |-> source_level[17] == s_ff.field[17]
  ) else $error("ext irq4 middle code not linear");

  // upper half and gap bits of every read are zero
  chk_read_zero_bits: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:15] == 17'h0_0000 && s_axi_rdata[11] == 1'b0
      && s_axi_rdata[7] == 1'b0 && s_axi_rdata[3] == 1'b0
  ) else $error("unimplemented read bit not zero");

  // first cycle after reset shows level 4
  chk_reset_level: assert property (
    !$past(aresetn) |-> source_level[5] == 3'h4 && source_level[18] == 3'h4 && source_req == '0
  ) else $error("reset level not 4");

  // register 0 upper lane lands in timer4
  chk_reg0_timer4: assert property (
    wr.en && wr.idx == 3'h0 && wr.strb[1] |=> s_ff.field[0] == $past(wr.data[14:12])
  ) else $error("register 0 write missed timer4");

  // register 1 low lane lands in timer5
  chk_reg1_timer5: assert property (
    wr.en && wr.idx == 3'h1 && wr.strb[0] |=> s_ff.field[7] == $past(wr.data[2:0])
  ) else $error("register 1 write missed timer5");

  // register 2 lands in spi2 event at 6-4
  chk_reg2_spi2: assert property (
    wr.en && wr.idx == 3'h2 && wr.strb[0] |=> s_ff.field[10] == $past(wr.data[6:4])
  ) else $error("register 2 write missed spi2 event");

  // can sources stay off without the controller
  chk_can_absent: assert property (
    !CAN_PRESENT |-> source_level[8] == 3'h0 && !source_req[9] && source_level[9] == 3'h0
  ) else $error("can source active without controller");

  // register 3 lands in capture4 at 10-8
  chk_reg3_capture4: assert property (
    wr.en && wr.idx == 3'h3 && wr.strb[1] |=> s_ff.field[12] == $past(wr.data[10:8])
  ) else $error("register 3 write missed capture4");

  // register 4 lands in i2c2 slave at 6-4
  chk_reg4_i2c2: assert property (
    wr.en && wr.idx == 3'h4 && wr.strb[0] |=> s_ff.field[16] == $past(wr.data[6:4])
  ) else $error("register 4 write missed i2c2 slave");

  // register 5 lands in ext irq4 at 10-8
  chk_reg5_extirq4: assert property (
    wr.en && wr.idx == 3'h5 && wr.strb[1] |=> s_ff.field[17] == $past(wr.data[10:8])
  ) else $error("register 5 write missed ext irq4");

  // write answer follows both halves within two cycles
  chk_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid |-> ##[1:2] s_axi_bvalid
  ) else $error("write response late");

  // read answer the cycle after the address is taken
  chk_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready
  ) else $error("read response late");
endmodule : prio_regs

// file: bench/testbench.sv
// testbench: self-checking bench for the interrupt priority register bank
`timescale 1ns/1ns
module testbench;
  // ****************
  // expected values
  // ****************
  localparam logic [31:0] RST_WORD [6] = '{32'h0000_4444, 32'h0000_4444, 32'h0000_4444, 32'h0000_0444,
                                           32'h0000_0440, 32'h0000_0440};
  localparam logic [31:0] ALL_MASK [6] = '{32'h0000_7777, 32'h0000_7777, 32'h0000_7777, 32'h0000_0777,
                                           32'h0000_0770, 32'h0000_0770};
  localparam int EXP_REG [19] = '{0, 0, 0, 0, 1, 1, 1, 1, 2, 2, 2, 2, 3, 3, 3, 4, 4, 5, 5};
  localparam int EXP_LSB [19] = '{12, 8, 4, 0, 12, 8, 4, 0, 12, 8, 4, 0, 8, 4, 0, 8, 4, 8, 4};

  // clock, reset, bus and source signals
  logic              aclk;
  logic              aresetn;
  logic [7:0]        s_axi_awaddr;
  logic              s_axi_awvalid;
  logic              s_axi_awready;
  logic [31:0]       s_axi_wdata;
  logic [3:0]        s_axi_wstrb;
  logic              s_axi_wvalid;
  logic              s_axi_wready;
  logic [1:0]        s_axi_bresp;
  logic              s_axi_bvalid;
  logic              s_axi_bready;
  logic [7:0]        s_axi_araddr;
  logic [2:0]        s_axi_awprot;
  logic [2:0]        s_axi_arprot;
  logic              s_axi_arvalid;
  logic              s_axi_arready;
  logic [31:0]       s_axi_rdata;
  logic [1:0]        s_axi_rresp;
  logic              s_axi_rvalid;
  logic              s_axi_rready;
  logic [18:0]       source_flag;
  logic [18:0][2:0]  source_level;
  logic [18:0]       source_req;
  logic [18:0][2:0]  level_nocan;
  logic [18:0]       req_nocan;
  int                bad_count;
  int                tests_run;

  // ****************
  // design under test and a variant without the can controller
  // ****************
  prio_regs #(.CAN_PRESENT(1'b1)) DUT (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(s_axi_awprot),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arprot(s_axi_arprot), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .source_flag(source_flag),
    .source_level(source_level), .source_req(source_req));
  prio_regs #(.CAN_PRESENT(1'b0)) DUT_NOCAN (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(s_axi_awprot),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(),
    .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arprot(s_axi_arprot), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(s_axi_rready),
    .source_flag(source_flag), .source_level(level_nocan), .source_req(req_nocan));

  // clock of 10 ns period
  always #5 aclk = ~aclk;

  // ****************
  // shared tasks
  // ****************
  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    tests_run++;
    if (seen !== expv) begin
      bad_count++;
      $display("[FAIL] time %0t seen %h expected %h", $time, seen, expv);
    end
  endtask : check

  // one write: address and data offered together, bready held until bvalid
  task automatic bus_write(input logic [7:0] addr, input logic [31:0] data, input logic [3:0] strb,
                           output logic [1:0] resp);
    @(posedge aclk);
    s_axi_awaddr  <= addr;
    s_axi_wdata   <= data;
    s_axi_wstrb   <= strb;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : bus_write

  // one read: rready held until rvalid
  task automatic bus_read(input logic [7:0] addr, output logic [31:0] data, output logic [1:0] resp);
    @(posedge aclk);
    s_axi_araddr  <= addr;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    data = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : bus_read

  // ****************
  // scenarios
  // ****************
  // reset values of every register and every level
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0]  rsp;
    for (int r = 0; r < 6; r++) begin
      bus_read(prio_regs_pkg::REG_OFS[r], d, rsp);
      check(d, RST_WORD[r]);
      check(32'(rsp), 32'h0000_0000);
    end
    for (int s = 0; s < 19; s++) begin
      check(32'(source_level[s]), 32'h0000_0004);
      check(32'(level_nocan[s]), (s == 8 || s == 9) ? 32'h0000_0000 : 32'h0000_0004);
    end
  endtask : t_reset

  // all ones written, only implemented field bits read back
  task automatic t_ones;
    logic [31:0] d;
    logic [1:0]  rsp;
    // protection bits raised from here on; they must change nothing
    s_axi_awprot <= 3'h7;
    s_axi_arprot <= 3'h7;
    for (int r = 0; r < 6; r++) begin
      bus_write(prio_regs_pkg::REG_OFS[r], 32'hffff_ffff, 4'hf, rsp);
      check(32'(rsp), 32'h0000_0000);
      bus_read(prio_regs_pkg::REG_OFS[r], d, rsp);
      check(d, ALL_MASK[r]);
    end
  endtask : t_ones

  // lower byte lane off leaves the two lower fields alone
  task automatic t_strobe;
    logic [31:0] d;
    logic [1:0]  rsp;
    bus_write(prio_regs_pkg::REG_OFS[0], 32'h0000_0000, 4'h2, rsp);
    bus_read(prio_regs_pkg::REG_OFS[0], d, rsp);
    check(d, 32'h0000_0077);
  endtask : t_strobe

  // unmapped and unaligned places refuse without side effects
  task automatic t_unmapped;
    logic [31:0] d;
    logic [1:0]  rsp;
    bus_write(8'h18, 32'h0000_0000, 4'hf, rsp);
    check(32'(rsp), 32'h0000_0002);
    bus_read(8'h18, d, rsp);
    check(d, 32'h0000_0000);
    check(32'(rsp), 32'h0000_0002);
    bus_read(8'h02, d, rsp);
    check(32'(rsp), 32'h0000_0002);
    bus_read(prio_regs_pkg::REG_OFS[0], d, rsp);
    check(d, 32'h0000_0077);
  endtask : t_unmapped

  // every code at every source, code offset by source index modulo 8, with flags raised
  task automatic t_levels;
    logic [31:0] w [6];
    logic [2:0]  code [19];
    logic [1:0]  rsp;
    for (int k = 0; k < 8; k++) begin
      w = '{default: 32'h0000_0000};
      for (int s = 0; s < 19; s++) begin
        code[s] = 3'((s + k) % 8);
        w[EXP_REG[s]] = w[EXP_REG[s]] | (32'(code[s]) << EXP_LSB[s]);
      end
      source_flag <= 19'h0_0000;
      for (int r = 0; r < 6; r++) bus_write(prio_regs_pkg::REG_OFS[r], w[r], 4'hf, rsp);
      @(posedge aclk);
      source_flag <= 19'h7_ffff;
      @(negedge aclk);
      check(32'(source_req), 32'h0000_0000);
      @(negedge aclk);
      for (int s = 0; s < 19; s++) begin
        check(32'(source_level[s]), 32'(code[s]));
        check(32'(source_req[s]), 32'(code[s] != 3'h0));
        check(32'(level_nocan[s]), (s == 8 || s == 9) ? 32'h0000_0000 : 32'(code[s]));
        check(32'(req_nocan[s]), (s == 8 || s == 9) ? 32'h0000_0000 : 32'(code[s] != 3'h0));
      end
    end
  endtask : t_levels

  // verdict and end of run
  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude

  // ****************
  // main sequence
  // ****************
  initial begin
    aclk          = 1'b0;
    aresetn       = 1'b0;
    s_axi_awaddr  = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata   = 32'h0000_0000;
    s_axi_wstrb   = 4'h0;
    s_axi_wvalid  = 1'b0;
    s_axi_bready  = 1'b0;
    s_axi_araddr  = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready  = 1'b0;
    s_axi_awprot  = 3'h0;
    s_axi_arprot  = 3'h0;
    source_flag   = 19'h7_ffff;
    bad_count     = 0;
    tests_run     = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    check(32'(source_req), 32'h0000_0000);
    t_reset();
    t_ones();
    t_strobe();
    t_unmapped();
    t_levels();
    conclude();
  end

  // watchdog against a hung handshake
  initial begin
    #200_000;
    bad_count++;
    conclude();
  end
endmodule : testbench
